// [include/awer_pkg.sv]
// Package of constants and carrier types for the auxiliary wake event registers.
package awer_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] IDX_FORCE_CHANGE = 8'hc1;
  localparam logic [7:0] IDX_RATE_SHADOW = 8'hc2;
  localparam logic [7:0] IDX_FIFO1_SHADOW = 8'hc3;
  localparam logic [7:0] IDX_FIFO2_SHADOW = 8'hc4;
  localparam logic [7:0] IDX_MASTER_CTRL = 8'hc5;
  localparam logic [7:0] IDX_MASTER_STAT = 8'hc6;
  localparam logic [7:0] IDX_SRC_STATUS = 8'hc7;
  localparam logic [7:0] IDX_SRC_ENABLE = 8'hc8;
  localparam logic [7:0] IDX_ADDR_QUAL = 8'h24;

  // Bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 5;

  // Field positions.
  localparam int POS_MASTER_EN = 0;
  localparam int POS_MASTER_FLAG = 0;
  localparam int POS_FORCE_CHANGE = 0;
  localparam int POS_ADDR_QUAL = 6;
  localparam int POS_SRC_INFRARED = 0;
  localparam int POS_SRC_RING_TWO = 1;
  localparam int POS_SRC_RING_ONE = 2;
  localparam int POS_SRC_KEYBOARD = 3;
  localparam int POS_SRC_MOUSE = 4;

  // Reset values.
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_SHADOW = 8'h00;
  localparam logic RST_FORCE_CHANGE = 1'b1;
  localparam logic RST_ADDR_QUAL = 1'b0;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write of a write-only setting elsewhere in the device, to be shadowed.
  typedef struct packed {
    logic stb;
    logic [7:0] data;
  } awer_shadow_wr_t;

endpackage

// [verilog/awer_top.sv]
// Auxiliary wake event register group with an AXI4-Lite register slave.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module awer_top #(
  // Zero keeps the write-one-clears enable; one makes a written one set it.
  parameter bit ENABLE_WRITE_SETS = 1'b0
) (
  // Clock and standby-supply power-on reset.
  input wire logic clk,
  input wire logic reset_n,
  // Main-supply, soft or hard reset of the rest of the device.
  input wire logic mainReset,
  // AXI4-Lite slave.
  input wire logic [awer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [awer_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [awer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [awer_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Wake sources and the open-drain wake request.
  input wire logic [awer_pkg::NUM_SRC-1:0] wakeEvent,
  input wire logic wakeRequestIn_n,
  output logic wakeRequestOut_n,
  output logic wakeRequestOe,
  // Write-only settings seen elsewhere in the device.
  input wire awer_pkg::awer_shadow_wr_t rateWrite,
  input wire awer_pkg::awer_shadow_wr_t fifoOneWrite,
  input wire awer_pkg::awer_shadow_wr_t fifoTwoWrite,
  // Floppy drive signals.
  input wire logic drive_select_zero_n,
  input wire logic head_step_pulse_n,
  input wire logic disk_changed_pin_n,
  output logic disk_changed_flag,
  // Shared request-to-send and address pin.
  input wire logic portTwoRtsCore_n,
  input wire logic rtsPinIn,
  output logic rtsPinOut,
  output logic rtsPinOe,
  output logic address_line_twelve
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic rstMeta_ff;
  logic rstSync_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  wire rstN = rstSync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are held until both are present.
  logic awHeld_ff;
  logic wHeld_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic [awer_pkg::ADDR_W-1:0] awAddr_ff;
  logic [7:0] wData_ff;
  logic wLane_ff;
  wire awTake = s_axi_awvalid & ~awHeld_ff;
  wire wTake = s_axi_wvalid & ~wHeld_ff;
  wire wrFire = awHeld_ff & wHeld_ff & ~bValid_ff;
  wire [7:0] wrIdx = awAddr_ff[9:2];
  wire wrAligned = (awAddr_ff[1:0] == 2'h0) & (awAddr_ff[11:10] == 2'h0);
  wire wrMapped = wrAligned & (((wrIdx >= awer_pkg::IDX_FORCE_CHANGE) &
    (wrIdx <= awer_pkg::IDX_SRC_ENABLE)) | (wrIdx == awer_pkg::IDX_ADDR_QUAL));
  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready = ~wHeld_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= awer_pkg::RESP_OKAY;
      awAddr_ff <= '0;
      wData_ff <= 8'h00;
      wLane_ff <= 1'b0;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_ff <= 1'b0;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata[7:0];
        wLane_ff <= s_axi_wstrb[0];
      end else if (wrFire) begin
        wHeld_ff <= 1'b0;
      end
      if (wrFire) begin
        bValid_ff <= 1'b1;
        bResp_ff <= wrMapped ? awer_pkg::RESP_OKAY : awer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  // Decoded write strobes; only byte lane zero carries register bits.
  wire wrHit = wrFire & wrAligned & wLane_ff;
  wire wrForce = wrHit & (wrIdx == awer_pkg::IDX_FORCE_CHANGE);
  wire wrMasterCtrl = wrHit & (wrIdx == awer_pkg::IDX_MASTER_CTRL);
  wire wrMasterStat = wrHit & (wrIdx == awer_pkg::IDX_MASTER_STAT);
  wire wrSrcStatus = wrHit & (wrIdx == awer_pkg::IDX_SRC_STATUS);
  wire wrSrcEnable = wrHit & (wrIdx == awer_pkg::IDX_SRC_ENABLE);
  wire wrAddrQual = wrHit & (wrIdx == awer_pkg::IDX_ADDR_QUAL);

  ////////////////////////////////////////////////////////////////////////////
  // Wake registers, cleared only by the standby power-on reset.
  logic masterEn_ff;
  logic masterFlag_ff;
  logic [awer_pkg::NUM_SRC-1:0] srcStatus_ff;
  logic [awer_pkg::NUM_SRC-1:0] srcEnable_ff;

  wire [awer_pkg::NUM_SRC-1:0] wakeGated = wakeEvent & srcEnable_ff;
  wire anyEnabledWake = |wakeGated;
  wire flagClear = wrMasterStat & wData_ff[awer_pkg::POS_MASTER_FLAG];
  // A new enabled event beats a clear in the same cycle.
  wire nxt_masterFlag = (masterFlag_ff & ~flagClear) | anyEnabledWake;
  wire nxt_masterEn = wrMasterCtrl ? wData_ff[awer_pkg::POS_MASTER_EN] :
    masterEn_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      masterEn_ff <= awer_pkg::RST_WAKE[0];
      masterFlag_ff <= awer_pkg::RST_WAKE[0];
    end else begin
      masterEn_ff <= nxt_masterEn;
      masterFlag_ff <= nxt_masterFlag;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < awer_pkg::NUM_SRC; gi++) begin : gSrc
      wire stClr = wrSrcStatus & wData_ff[gi];
      wire enWr = wrSrcEnable & wData_ff[gi];
      wire nxt_status = (srcStatus_ff[gi] & ~stClr) | wakeEvent[gi];
      wire nxt_enable = enWr ? ENABLE_WRITE_SETS : srcEnable_ff[gi];

      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          srcStatus_ff[gi] <= awer_pkg::RST_WAKE[gi];
          srcEnable_ff[gi] <= awer_pkg::RST_WAKE[gi];
        end else begin
          srcStatus_ff[gi] <= nxt_status;
          srcEnable_ff[gi] <= nxt_enable;
        end
      end
    end
  endgenerate

  // Open drain: the pin is only ever pulled low.
  assign wakeRequestOut_n = 1'b0;
  assign wakeRequestOe = masterFlag_ff & masterEn_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Device state; all but diskChanged_ff and addrTwelve_ff follow the main-supply and soft resets.
  logic forceChange_ff;
  logic addrQual_ff;
  logic [7:0] rateShadow_ff;
  logic [7:0] fifoOneShadow_ff;
  logic [7:0] fifoTwoShadow_ff;
  logic diskChanged_ff;
  logic addrTwelve_ff;

  wire driveActivity = ~head_step_pulse_n | ~drive_select_zero_n;
  wire forceSet = wrForce & wData_ff[awer_pkg::POS_FORCE_CHANGE];
  // Software may only set the flag; a set in a busy cycle still lands.
  wire nxt_forceChange = forceSet | (forceChange_ff & ~driveActivity);
  wire nxt_addrQual = wrAddrQual ? wData_ff[awer_pkg::POS_ADDR_QUAL] :
    addrQual_ff;
  wire nxt_diskChanged = (drive_select_zero_n & forceChange_ff) |
    disk_changed_pin_n;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      forceChange_ff <= awer_pkg::RST_FORCE_CHANGE;
      addrQual_ff <= awer_pkg::RST_ADDR_QUAL;
      rateShadow_ff <= awer_pkg::RST_SHADOW;
      fifoOneShadow_ff <= awer_pkg::RST_SHADOW;
      fifoTwoShadow_ff <= awer_pkg::RST_SHADOW;
    end else if (mainReset) begin
      forceChange_ff <= awer_pkg::RST_FORCE_CHANGE;
      addrQual_ff <= awer_pkg::RST_ADDR_QUAL;
      rateShadow_ff <= awer_pkg::RST_SHADOW;
      fifoOneShadow_ff <= awer_pkg::RST_SHADOW;
      fifoTwoShadow_ff <= awer_pkg::RST_SHADOW;
    end else begin
      forceChange_ff <= nxt_forceChange;
      addrQual_ff <= nxt_addrQual;
      if (rateWrite.stb) begin
        rateShadow_ff <= rateWrite.data;
      end
      if (fifoOneWrite.stb) begin
        fifoOneShadow_ff <= fifoOneWrite.data;
      end
      if (fifoTwoWrite.stb) begin
        fifoTwoShadow_ff <= fifoTwoWrite.data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      diskChanged_ff <= 1'b0;
      addrTwelve_ff <= 1'b0;
    end else begin
      diskChanged_ff <= nxt_diskChanged;
      addrTwelve_ff <= addrQual_ff & rtsPinIn;
    end
  end

  assign disk_changed_flag = diskChanged_ff;
  assign address_line_twelve = addrTwelve_ff;
  // With the qualify bit set the pin becomes an address input.
  assign rtsPinOe = ~addrQual_ff;
  assign rtsPinOut = portTwoRtsCore_n;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  logic rValid_ff;
  logic [7:0] rData_ff;
  logic [1:0] rResp_ff;

  wire arTake = s_axi_arvalid & ~rValid_ff;
  wire [7:0] rdIdx = s_axi_araddr[9:2];
  wire rdAligned = (s_axi_araddr[1:0] == 2'h0) &
    (s_axi_araddr[11:10] == 2'h0);
  wire rdForce = rdIdx == awer_pkg::IDX_FORCE_CHANGE;
  wire rdRate = rdIdx == awer_pkg::IDX_RATE_SHADOW;
  wire rdFifoOne = rdIdx == awer_pkg::IDX_FIFO1_SHADOW;
  wire rdFifoTwo = rdIdx == awer_pkg::IDX_FIFO2_SHADOW;
  wire rdMasterCtrl = rdIdx == awer_pkg::IDX_MASTER_CTRL;
  wire rdMasterStat = rdIdx == awer_pkg::IDX_MASTER_STAT;
  wire rdSrcStatus = rdIdx == awer_pkg::IDX_SRC_STATUS;
  wire rdSrcEnable = rdIdx == awer_pkg::IDX_SRC_ENABLE;
  wire rdAddrQual = rdIdx == awer_pkg::IDX_ADDR_QUAL;
  wire rdMapped = rdAligned & (rdForce | rdRate | rdFifoOne | rdFifoTwo |
    rdMasterCtrl | rdMasterStat | rdSrcStatus | rdSrcEnable | rdAddrQual);
  // Reserved bits read as zero.
  wire [7:0] rdMux =
    rdForce ? {7'h00, forceChange_ff} :
    rdRate ? {rateShadow_ff[7:6], 1'b0, rateShadow_ff[4:0]} :
    rdFifoOne ? {fifoOneShadow_ff[7:6], 2'h0, fifoOneShadow_ff[3:0]} :
    rdFifoTwo ? {fifoTwoShadow_ff[7:6], 2'h0, fifoTwoShadow_ff[3:0]} :
    rdMasterCtrl ? {7'h00, masterEn_ff} :
    rdMasterStat ? {7'h00, masterFlag_ff} :
    rdSrcStatus ? {3'h0, srcStatus_ff} :
    rdSrcEnable ? {3'h0, srcEnable_ff} :
    rdAddrQual ? {1'b0, addrQual_ff, 6'h00} : 8'h00;

  assign s_axi_arready = ~rValid_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = {24'h000000, rData_ff};
  assign s_axi_rresp = rResp_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rValid_ff <= 1'b0;
      rData_ff <= 8'h00;
      rResp_ff <= awer_pkg::RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff <= rdAligned ? rdMux : 8'h00;
      rResp_ff <= rdMapped ? awer_pkg::RESP_OKAY : awer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  master_gate_a: assert property (!masterEn_ff |-> !wakeRequestOe)
    else $error("wake request driven with master enable low");
  enabled_drive_a: assert property (
    anyEnabledWake && masterEn_ff && !wrMasterCtrl |=> wakeRequestOe)
    else $error("enabled wake event did not drive the request");
  flag_independent_a: assert property (
    anyEnabledWake |=> masterFlag_ff)
    else $error("master flag not set by an enabled event");
  flag_clear_a: assert property (
    flagClear && !anyEnabledWake |=> !masterFlag_ff && !wakeRequestOe)
    else $error("writing one did not clear the master flag");
  zero_write_a: assert property (
    wrMasterStat && !wData_ff[0] && masterFlag_ff |=> masterFlag_ff)
    else $error("writing zero changed the master flag");
  source_record_a: assert property (
    1'b1 |=> (srcStatus_ff & $past(wakeEvent)) == $past(wakeEvent))
    else $error("source event not recorded");
  source_clear_a: assert property (
    wrSrcStatus && wData_ff[0] && !wakeEvent[0] |=> !srcStatus_ff[0])
    else $error("source status not cleared by a written one");
  disabled_block_a: assert property (
    !anyEnabledWake && !masterFlag_ff |=> !masterFlag_ff)
    else $error("disabled source raised the master flag");
  keep_wake_a: assert property (
    mainReset && !wrMasterCtrl |=> $stable(masterEn_ff))
    else $error("main reset disturbed the master enable");
  enable_write_a: assert property (
    wrSrcEnable && !wData_ff[1] |=> srcEnable_ff[1] == $past(srcEnable_ff[1]))
    else $error("writing zero changed a source enable");
  // The flop still holds its reset value one edge after release.
  disk_change_a: assert property (
    rstN |=> disk_changed_flag == (($past(drive_select_zero_n) &
      $past(forceChange_ff)) | $past(disk_changed_pin_n)))
    else $error("disk change indication wrong");
  rts_mux_a: assert property (
    !addrQual_ff |-> rtsPinOe && rtsPinOut == portTwoRtsCore_n)
    else $error("request-to-send pin not driven");
  force_clear_a: assert property (
    driveActivity && !forceSet && !mainReset |=> !forceChange_ff)
    else $error("forced change not cleared by drive activity");
  read_answer_a: assert property (arTake |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  wake_seen_c: cover property (anyEnabledWake ##1 wakeRequestOe);
  wake_cleared_c: cover property (wakeRequestOe ##1 flagClear ##1
    !wakeRequestOe);
  clear_race_c: cover property (flagClear && anyEnabledWake);
  qualify_c: cover property (wrAddrQual ##1 !rtsPinOe);

endmodule

// [verif/awer_wake_host.sv]
// Host-side model of the open-drain wake request line.
`timescale 1ns/1ps
module awer_wake_host (
  // Clock.
  input wire logic clk,
  // Device side of the open-drain line.
  input wire logic wakeRequestOut_n,
  input wire logic wakeRequestOe,
  // Resolved line and the host's latched view of it.
  output logic wakeLine_n,
  output logic wakeSeen
);
  // A released line floats up to the pull-up, never holding a stale low.
  assign wakeLine_n = wakeRequestOe ? wakeRequestOut_n : 1'b1;
  always_ff @(posedge clk) begin
    wakeSeen <= ~wakeLine_n;
  end
endmodule

// [verif/test_aux_wake_event_registers.sv]
// Self-checking bench for the auxiliary wake event registers.
`timescale 1ns/1ps
module test_aux_wake_event_registers;
  localparam logic [7:0] FRC = awer_pkg::IDX_FORCE_CHANGE;
  localparam logic [7:0] CTL = awer_pkg::IDX_MASTER_CTRL;
  localparam logic [7:0] STA = awer_pkg::IDX_MASTER_STAT;
  localparam logic [7:0] SRC = awer_pkg::IDX_SRC_STATUS;
  localparam logic [7:0] ENA = awer_pkg::IDX_SRC_ENABLE;
  localparam logic [1:0] OK = awer_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = awer_pkg::RESP_SLVERR;
  logic clk, reset_n, mainReset;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] wakeEvent;
  logic wakeRequestOut_n, wakeRequestOe, wakeLine_n, wakeSeen;
  awer_pkg::awer_shadow_wr_t rateWrite, fifoOneWrite, fifoTwoWrite;
  logic drive_select_zero_n, head_step_pulse_n, disk_changed_pin_n;
  logic disk_changed_flag, portTwoRtsCore_n, rtsPinOut, rtsPinOe;
  logic address_line_twelve, extDrive, extLevel, rtsLine;
  int errorCnt, samplesChecked;

  // Unconnected address input reads low, hence the pull-down.
  assign rtsLine = rtsPinOe ? rtsPinOut : (extDrive ? extLevel : 1'b0);

  // Written ones set the enables so that wake requests can be exercised;
  // the cost is that the one-clears reading of the enable goes untested.
  awer_top #(.ENABLE_WRITE_SETS(1'b1)) awer_top_i (
    .clk(clk), .reset_n(reset_n), .mainReset(mainReset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wakeEvent(wakeEvent),
    .wakeRequestIn_n(wakeLine_n), .wakeRequestOut_n(wakeRequestOut_n),
    .wakeRequestOe(wakeRequestOe), .rateWrite(rateWrite),
    .fifoOneWrite(fifoOneWrite), .fifoTwoWrite(fifoTwoWrite),
    .drive_select_zero_n(drive_select_zero_n),
    .head_step_pulse_n(head_step_pulse_n),
    .disk_changed_pin_n(disk_changed_pin_n),
    .disk_changed_flag(disk_changed_flag),
    .portTwoRtsCore_n(portTwoRtsCore_n), .rtsPinIn(rtsLine),
    .rtsPinOut(rtsPinOut), .rtsPinOe(rtsPinOe),
    .address_line_twelve(address_line_twelve)
  );

  awer_wake_host awer_wake_host_i (
    .clk(clk), .wakeRequestOut_n(wakeRequestOut_n),
    .wakeRequestOe(wakeRequestOe), .wakeLine_n(wakeLine_n),
    .wakeSeen(wakeSeen)
  );

////////////////////////////////////////////////////////////////////////////////
  task automatic stopTest;
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      errorCnt++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      end
      if (n == 64) begin
        errorCnt++;
        stopTest();
      end
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                       input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk($sformatf("reg %h", idx), {24'h0, exp}, s_axi_rdata);
      end
      if (n == 64) begin
        errorCnt++;
        stopTest();
      end
    end
  endtask

  // Pulse wake sources, then stop just after the capturing edge.
  task automatic evt(input logic [4:0] m);
    @(posedge clk);
    wakeEvent <= m;
    @(posedge clk);
    wakeEvent <= 5'h00;
    @(negedge clk);
  endtask

  task automatic settle;
    repeat (2) @(negedge clk);
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    stopTest();
  end

  initial begin
    {reset_n, mainReset, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, wakeEvent, extDrive, extLevel} = '0;
    {rateWrite, fifoOneWrite, fifoTwoWrite} = '0;
    {drive_select_zero_n, head_step_pulse_n, portTwoRtsCore_n} = 3'h7;
    disk_changed_pin_n = 1'b0;
    errorCnt = 0;
    samplesChecked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(CTL, awer_pkg::RST_WAKE, OK);
    rdchk(STA, awer_pkg::RST_WAKE, OK);
    rdchk(SRC, awer_pkg::RST_WAKE, OK);
    rdchk(ENA, awer_pkg::RST_WAKE, OK);
    @(posedge clk);
    rateWrite <= '{1'b1, 8'hff};
    fifoOneWrite <= '{1'b1, 8'hff};
    fifoTwoWrite <= '{1'b1, 8'h5a};
    @(posedge clk);
    {rateWrite, fifoOneWrite, fifoTwoWrite} <= '0;
    rdchk(awer_pkg::IDX_RATE_SHADOW, 8'hdf, OK);
    rdchk(awer_pkg::IDX_FIFO1_SHADOW, 8'hcf, OK);
    rdchk(awer_pkg::IDX_FIFO2_SHADOW, 8'h4a, OK);
    for (int i = 0; i < 5; i++) begin
      evt(5'h01 << i);
      chk("wake oe", 32'h0, {31'h0, wakeRequestOe});
      rdchk(SRC, (8'h02 << i) - 8'h01, OK);
    end
    rdchk(STA, 8'h00, OK);
    wr(SRC, 8'h00, OK);
    rdchk(SRC, 8'h1f, OK);
    wr(SRC, 8'h04, OK);
    rdchk(SRC, 8'h1b, OK);
    wr(SRC, 8'h1f, OK);
    rdchk(SRC, 8'h00, OK);
    wr(ENA, 8'h00, OK);
    rdchk(ENA, 8'h00, OK);
    wr(ENA, 8'h09, OK);
    evt(5'h08);
    chk("wake line", 32'h1, {31'h0, wakeLine_n});
    rdchk(STA, 8'h01, OK);
    wr(CTL, 8'h01, OK);
    settle();
    chk("wake line", 32'h0, {31'h0, wakeLine_n});
    chk("host seen", 32'h1, {31'h0, wakeSeen});
    wr(STA, 8'h00, OK);
    rdchk(STA, 8'h01, OK);
    @(posedge clk);
    mainReset <= 1'b1;
    @(posedge clk);
    mainReset <= 1'b0;
    rdchk(CTL, 8'h01, OK);
    rdchk(STA, 8'h01, OK);
    rdchk(SRC, 8'h08, OK);
    rdchk(ENA, 8'h09, OK);
    wr(STA, 8'h01, OK);
    settle();
    chk("wake line", 32'h1, {31'h0, wakeLine_n});
    rdchk(STA, 8'h00, OK);
    evt(5'h02);
    chk("wake oe", 32'h0, {31'h0, wakeRequestOe});
    evt(5'h01);
    chk("wake oe", 32'h1, {31'h0, wakeRequestOe});
    wr(CTL, 8'h00, OK);
    settle();
    chk("wake oe", 32'h0, {31'h0, wakeRequestOe});
    rdchk(STA, 8'h01, OK);
    chk("disk chg", 32'h1, {31'h0, disk_changed_flag});
    @(posedge clk);
    drive_select_zero_n <= 1'b0;
    @(posedge clk);
    drive_select_zero_n <= 1'b1;
    settle();
    chk("disk chg", 32'h0, {31'h0, disk_changed_flag});
    @(posedge clk);
    disk_changed_pin_n <= 1'b1;
    settle();
    chk("disk chg", 32'h1, {31'h0, disk_changed_flag});
    @(posedge clk);
    disk_changed_pin_n <= 1'b0;
    wr(FRC, 8'h01, OK);
    settle();
    chk("disk chg", 32'h1, {31'h0, disk_changed_flag});
    wr(FRC, 8'h00, OK);
    settle();
    chk("disk chg", 32'h1, {31'h0, disk_changed_flag});
    @(posedge clk);
    head_step_pulse_n <= 1'b0;
    @(posedge clk);
    head_step_pulse_n <= 1'b1;
    settle();
    chk("disk chg", 32'h0, {31'h0, disk_changed_flag});
    @(posedge clk);
    portTwoRtsCore_n <= 1'b0;
    settle();
    chk("rts line", 32'h0, {31'h0, rtsLine});
    chk("rts oe", 32'h1, {31'h0, rtsPinOe});
    wr(awer_pkg::IDX_ADDR_QUAL, 8'h40, OK);
    extDrive <= 1'b1;
    extLevel <= 1'b1;
    settle();
    chk("rts oe", 32'h0, {31'h0, rtsPinOe});
    chk("addr12", 32'h1, {31'h0, address_line_twelve});
    @(posedge clk);
    extDrive <= 1'b0;
    settle();
    chk("addr12", 32'h0, {31'h0, address_line_twelve});
    wr(8'hff, 8'h01, ERR);
    rdchk(8'hff, 8'h00, ERR);
    stopTest();
  end
endmodule
